// ---- dv/sps_far.sv ----
// Purpose: far side link clock. Assumes: 160 ns period. Notes: stands low while disabled
`timescale 1ns/1ps
module sps_far #(
  parameter OFS = 7
) (
  input  wire en,
  output reg  lclk
);
  initial
  begin
    lclk = 1'b0;
    #OFS;
    forever
    begin
      #80;
      lclk = en ? ~lclk : 1'b0;
    end
  end
endmodule

// ---- dv/sps_props.sv ----
// Purpose: poll status and rx lane checker. Assumes: top ports only. Notes: edge history covers sync delay
`timescale 1ns/1ps
module sps_props (
  input wire logic        ref_clk, rst_n, tfclk, rfclk, poll_status, single_port_lane_mode, rx_is_addr,
  input wire logic [1:0]  poll_addr,
  input wire logic [55:0] tx_fill_lvl, tx_high_wm, tx_low_wm,
  input wire logic [31:0] rx_data, rx_lane_data
);
  reg  [6:0]  th_r, rh_r;
  wire [13:0] lvl = tx_fill_lvl[poll_addr*14+:14];
  wire        t_rec = |(th_r[5:0] & ~th_r[6:1]);
  wire        r_rec = |(rh_r[5:0] & ~rh_r[6:1]);
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      {th_r, rh_r} <= 14'h0;
    else
      {th_r, rh_r} <= {th_r[5:0], tfclk, rh_r[5:0], rfclk};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence rx_moved;
    $changed(rx_data) || $changed(rx_lane_data);
  endsequence
  stat_edge_a: assert property ($changed(poll_status) |-> t_rec) else $error("status off edge");
  rx_edge_a: assert property (rx_moved |-> r_rec) else $error("rx off edge");
  rx_mark_a: assert property ($changed(rx_is_addr) |-> r_rec) else $error("mark off edge");
  word_mode_a: assert property ($changed(rx_data) && !single_port_lane_mode |-> rx_lane_data == 32'h0)
    else $error("lanes live");
  lane_mode_a: assert property ($changed(rx_lane_data) && single_port_lane_mode |-> rx_data == 32'h0)
    else $error("word live");
  stat_fall_a: assert property ($fell(poll_status) |-> lvl >= tx_low_wm[poll_addr*14+:14])
    else $error("bad fall");
  stat_rise_a: assert property ($rose(poll_status) |-> lvl < tx_high_wm[poll_addr*14+:14])
    else $error("bad rise");
  rst_high_a: assert property ($rose(rst_n) |-> poll_status) else $error("status low at reset");
endmodule

// ---- dv/sps_top_tb.sv ----
// Purpose: poll status and rx lane bench. Assumes: 160 ns link clocks. Notes: watermarks 200 and 100
`timescale 1ns/1ps
module sps_top_tb;
  reg         ref_clk = 0, rst_n = 0, tf_en = 0, rf_en = 0, single_port_lane_mode = 0, rx_in_valid = 0;
  reg  [3:0]  st = 4'hf;
  reg  [13:0] lp;
  reg  [1:0]  poll_addr = 0;
  reg  [55:0] tx_fill_lvl = 0, tx_high_wm = {4{14'd200}}, tx_low_wm = {4{14'd100}};
  reg  [32:0] rx_in_word = 0, w;
  reg  [32:0] q[$];
  reg  [13:0] tbl [0:5] = '{14'd150, 14'd200, 14'd150, 14'd100, 14'd99, 14'd199};
  wire        tfclk, rfclk, poll_status, rx_in_ready, rx_is_addr;
  wire [31:0] rx_data, rx_lane_data;
  integer     n_mismatch = 0, compares = 0, i, k;
  always #10 ref_clk = ~ref_clk;
  sps_far #(.OFS(7)) i_sps_far_t (.en(tf_en), .lclk(tfclk));
  sps_far #(.OFS(13)) i_sps_far_r (.en(rf_en), .lclk(rfclk));
  sps_top i_sps_top (.ref_clk(ref_clk), .rst_n(rst_n), .tfclk(tfclk), .poll_addr(poll_addr),
    .poll_status(poll_status), .tx_fill_lvl(tx_fill_lvl), .tx_high_wm(tx_high_wm), .tx_low_wm(tx_low_wm),
    .single_port_lane_mode(single_port_lane_mode), .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
    .rx_in_word(rx_in_word), .rfclk(rfclk), .rx_data(rx_data), .rx_is_addr(rx_is_addr), .rx_lane_data(rx_lane_data));
  task chk(input string nm, input [32:0] e, input [32:0] s);
    begin
      compares = compares + 1;
      if (e !== s)
      begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task stop_test;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task poll(input [13:0] l);
    begin
      @(negedge ref_clk);
      // distinct level per port so the address choice matters
      for (k = 0; k < 4; k = k + 1)
      begin
        lp = (l + 14'd60 * k[13:0]) % 14'd300;
        tx_fill_lvl[k*14+:14] = lp;
        st[k] = lp >= 14'd200 ? 1'b0 : lp < 14'd100 ? 1'b1 : st[k];
      end
      // let the old port settle before moving the address
      repeat (3) @(posedge tfclk);
      for (k = 0; k < 4; k = k + 1)
      begin
        @(negedge ref_clk);
        poll_addr = k[1:0];
        repeat (3) @(posedge tfclk);
        chk("poll_status", st[k], poll_status);
      end
    end
  endtask
  task xfer(input m);
    begin
      @(negedge ref_clk);
      single_port_lane_mode = m;
      repeat (40)
      begin
        @(negedge ref_clk);
        rx_in_word = {1'($urandom), $urandom};
        rx_in_valid = 1;
        if (rx_in_ready) q.push_back(rx_in_word);
      end
      @(negedge ref_clk);
      chk("rx_in_ready", 0, rx_in_ready);
      rx_in_valid = 0;
      rf_en = 1;
      @(posedge rfclk);
      while (q.size() > 0)
      begin
        @(posedge rfclk);
        w = q.pop_front();
        chk("rx_data", m ? 33'h0 : w[31:0], rx_data);
        chk("rx_lane_data", m ? w[31:0] : 32'h0, rx_lane_data);
        chk("rx_is_addr", w[32], rx_is_addr);
      end
      rf_en = 0;
      chk("rx_in_ready", 1, rx_in_ready);
    end
  endtask
  initial
  begin
    i = $urandom(32'hf3cd);
    repeat (10) @(negedge ref_clk);
    rst_n = 1;
    tf_en = 1;
    chk("poll_status", 1, poll_status);
    for (i = 0; i < 12; i = i + 1)
      poll(i < 6 ? tbl[i] : 14'($urandom % 300));
    tf_en = 0;
    xfer(0);
    xfer(1);
    stop_test;
  end
  initial
  begin
    #200000;
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
endmodule
bind sps_top sps_props i_sps_props (.ref_clk(ref_clk), .rst_n(rst_n), .tfclk(tfclk), .rfclk(rfclk),
  .poll_status(poll_status), .single_port_lane_mode(single_port_lane_mode), .rx_is_addr(rx_is_addr),
  .poll_addr(poll_addr), .tx_fill_lvl(tx_fill_lvl), .tx_high_wm(tx_high_wm), .tx_low_wm(tx_low_wm),
  .rx_data(rx_data), .rx_lane_data(rx_lane_data));

// ---- rtl/sps_fifo.v ----
// Purpose: small synchronous FIFO with valid/ready both sides
// Assumes: single clock, registered read data
// Notes: first-word-fall-through via output register
`timescale 1ns/1ps
module sps_fifo #(
  parameter W = 33,
  parameter D = 32,
  parameter AW = 5
) (
  // clock and reset
  input  wire          ref_clk,
  input  wire          rst_n,
  // fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // drain side
  output wire          out_valid,
  input  wire          out_ready,
  output reg  [W-1:0]  out_data
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW:0]   wr_ptr_r;
  reg [AW:0]   rd_ptr_r;
  reg          out_vld_r;
  wire         empty;
  wire         full;
  wire         pop;
  wire         push;

  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign full      = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
  assign in_ready  = ~full;
  assign push      = in_valid & ~full;
  assign out_valid = out_vld_r;
  // load output register when it is empty or being taken
  assign pop       = ~empty & (~out_vld_r | out_ready);

  always @(posedge ref_clk)
  begin
    if (push)
      mem[wr_ptr_r[AW-1:0]] <= in_data;
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r  <= {(AW+1){1'b0}};
      rd_ptr_r  <= {(AW+1){1'b0}};
      out_vld_r <= 1'b0;
      out_data  <= {W{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
      begin
        out_data <= mem[rd_ptr_r[AW-1:0]];
        rd_ptr_r <= rd_ptr_r + 1'b1;
        out_vld_r <= 1'b1;
      end
      else if (out_ready)
        out_vld_r <= 1'b0;
    end
  end
endmodule

// ---- rtl/sps_regs.vh ----
// Purpose: constants for the polled status and receive lane block
// Assumes: 50 MHz ref_clk, four ports, 33-bit receive word
// Notes: no software-visible registers
`ifndef SPS_REGS_VH
`define SPS_REGS_VH
`define SPS_NPORT       4
`define SPS_LVL_W       14
`define SPS_WORD_W      33
`define SPS_DATA_W      32
`define SPS_LANE_W      8
`define SPS_FIFO_DEPTH  32
`define SPS_FIFO_AW     5
`define SPS_ADDR_BIT    32
`define SPS_STAT_RST    1'b1
`endif

// ---- rtl/sps_top.v ----
// Purpose: polled transmit status and receive byte lane mapping
// Assumes: tfclk and rfclk sampled by ref_clk, both well below 25 MHz in the bench
// Notes: watermarks and fill levels come from neighbouring logic on ref_clk
`timescale 1ns/1ps
`include "sps_regs.vh"
module sps_top (
  // clock and reset
  input  wire                                  ref_clk,
  input  wire                                  rst_n,
  // transmit interface pins
  input  wire                                  tfclk,
  input  wire [1:0]                            poll_addr,
  output reg                                   poll_status,
  // transmit fifo levels and watermarks, packed per port
  input  wire [`SPS_NPORT*`SPS_LVL_W-1:0]      tx_fill_lvl,
  input  wire [`SPS_NPORT*`SPS_LVL_W-1:0]      tx_high_wm,
  input  wire [`SPS_NPORT*`SPS_LVL_W-1:0]      tx_low_wm,
  // mode select
  input  wire                                  single_port_lane_mode,
  // receive source: bit 32 marks an in-band address word
  input  wire                                  rx_in_valid,
  output wire                                  rx_in_ready,
  input  wire [`SPS_WORD_W-1:0]                rx_in_word,
  // receive interface pins
  input  wire                                  rfclk,
  output reg  [`SPS_DATA_W-1:0]                rx_data,
  output reg                                   rx_is_addr,
  output reg  [`SPS_NPORT*`SPS_LANE_W-1:0]     rx_lane_data
);
  // pin synchronisers
  reg  [1:0]  tfclk_s_r;
  reg  [1:0]  rfclk_s_r;
  reg  [1:0]  addr_s1_r;
  reg  [1:0]  addr_s2_r;
  reg         tfclk_d_r;
  reg         rfclk_d_r;
  reg  [1:0]  sel_port_r;
  reg  [`SPS_NPORT-1:0] stat_r;
  wire        tf_rise;
  wire        rf_rise;
  wire        fifo_vld;
  wire [`SPS_WORD_W-1:0] fifo_dat;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tfclk_s_r <= 2'h0;
      rfclk_s_r <= 2'h0;
      addr_s1_r <= 2'h0;
      addr_s2_r <= 2'h0;
      tfclk_d_r <= 1'b0;
      rfclk_d_r <= 1'b0;
    end
    else
    begin
      tfclk_s_r <= {tfclk_s_r[0], tfclk};
      rfclk_s_r <= {rfclk_s_r[0], rfclk};
      addr_s1_r <= poll_addr;
      addr_s2_r <= addr_s1_r;
      tfclk_d_r <= tfclk_s_r[1];
      rfclk_d_r <= rfclk_s_r[1];
    end
  end

  assign tf_rise = tfclk_s_r[1] & ~tfclk_d_r;
  assign rf_rise = rfclk_s_r[1] & ~rfclk_d_r;

  // per-port watermark hysteresis
  genvar g;
  generate
    for (g = 0; g < `SPS_NPORT; g = g + 1)
    begin : g_port
      wire [`SPS_LVL_W-1:0] lvl = tx_fill_lvl[g*`SPS_LVL_W +: `SPS_LVL_W];
      wire [`SPS_LVL_W-1:0] hwm = tx_high_wm[g*`SPS_LVL_W +: `SPS_LVL_W];
      wire [`SPS_LVL_W-1:0] lwm = tx_low_wm[g*`SPS_LVL_W +: `SPS_LVL_W];
      always @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          stat_r[g] <= `SPS_STAT_RST;
        else if (stat_r[g] && lvl >= hwm)
          stat_r[g] <= 1'b0;
        else if (!stat_r[g] && lvl < lwm)
          stat_r[g] <= 1'b1;
      end
    end
  endgenerate

  // polled status, updated only on tfclk rising edges
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_port_r  <= 2'h0;
      poll_status <= `SPS_STAT_RST;
    end
    else if (tf_rise)
    begin
      sel_port_r  <= addr_s2_r;
      poll_status <= stat_r[sel_port_r];
    end
  end

  // receive buffering
  sps_fifo #(
    .W  (`SPS_WORD_W),
    .D  (`SPS_FIFO_DEPTH),
    .AW (`SPS_FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .in_data   (rx_in_word),
    .out_valid (fifo_vld),
    .out_ready (rf_rise),
    .out_data  (fifo_dat)
  );

  // receive outputs
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_data      <= 32'h0;
      rx_is_addr   <= 1'b0;
      rx_lane_data <= 32'h0;
    end
    // outputs move on rfclk rising edge
    else if (rf_rise && fifo_vld)
    begin
      rx_is_addr <= fifo_dat[`SPS_ADDR_BIT];
      if (single_port_lane_mode)
      begin
        rx_data      <= 32'h0;
        rx_lane_data <= fifo_dat[`SPS_DATA_W-1:0];
      end
      else
      begin
        rx_data      <= fifo_dat[`SPS_DATA_W-1:0];
        rx_lane_data <= 32'h0;
      end
    end
  end
endmodule
